// [pkg/mm_timer_pkg.sv]
// Purpose: constants shared by the multimode down-counting timer
// Assumes: byte-wide memory-mapped register access from the core
// Notes:   addresses are the core's data addresses of the timer bytes
package mm_timer_pkg;

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [7:0] ADDR_RELOAD_LOW  = 8'haa;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hab;
  localparam logic [7:0] ADDR_COUNT_LOW   = 8'hac;
  localparam logic [7:0] ADDR_COUNT_HIGH  = 8'had;
  localparam logic [7:0] ADDR_CONTROL     = 8'hae;

  // ****************************************
  // control field positions
  // ****************************************
  localparam int MODE_MSB    = 7;
  localparam int MODE_LSB    = 5;
  localparam int RUN_BIT     = 4;
  localparam int PENDING_BIT = 3;
  localparam int IRQ_EN_BIT  = 2;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] COUNT_RESET  = 16'hffff;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;

  // ****************************************
  // mode field codes
  // ****************************************
  localparam logic [2:0] MODE_EVENT_RISE = 3'h0;
  localparam logic [2:0] MODE_EVENT_FALL = 3'h1;
  localparam logic [2:0] MODE_CAPT_RISE  = 3'h2;
  localparam logic [2:0] MODE_CAPT_FALL  = 3'h3;
  localparam logic [2:0] MODE_PWM_PLAIN  = 3'h4;
  localparam logic [2:0] MODE_PWM_TOGGLE = 3'h5;

endpackage : mm_timer_pkg

// [rtl/mm_timer.sv]
// Purpose: 16-bit down-counting timer with PWM, event count and capture modes
// Assumes: clk is the instruction clock; one byte access per cycle at most
// Notes:   timer_pin input is asynchronous and passes a 3-stage synchroniser
//
// Overview of operation
// - 16-bit counter, high/low byte access
// - 16-bit reload/capture register, two bytes
// - one pin shared with port bit two
// - counter decrements; software starts and stops outside capture
// - count clock or qualifying pin edges
// - underflow from 0000 outside capture: pending, toggle in toggle pwm; capture wraps to ffff
// - single interrupt, source set by mode
// - reset: counter ffff, reload 0000
// - bits 7..5 form mode field
// - bit 4 runs timer outside capture
// - bit 4 is underflow flag in capture
// - bit 3 is interrupt pending flag
// - bit 2 is interrupt enable
// - mode codes: event, capture, pwm
// - pwm/event underflow reloads, sets pending
// - capture edge copies counter, sets pending
// - irq needs pending or capture underflow, enable, global enable
`timescale 1ns/10ps

module mm_timer (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // memory-mapped byte access
  input  wire logic [7:0] addr,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  output logic            rd_hit,
  // core interrupt
  input  wire logic       global_irq_enable,
  output logic            timer_irq,
  // timer pin, alternate function of port bit two
  input  wire logic       timer_pin_in,
  input  wire logic [7:0] port_bit_two_out,
  output logic            timer_pin_toggle,
  output logic            timer_pin_out,
  output logic            timer_pin_is_timer
);

  logic [15:0] down_counter_r;
  logic [15:0] reload_capture_r;
  logic [2:0]  mode_r;
  logic        run_or_underflow_r;
  logic        timer_pending_r;
  logic        timer_irq_enable_r;
  logic        toggle_r;
  logic [2:0]  pin_sync_r;
  logic        pin_level_r;

  // ****************************************
  // mode decode
  // ****************************************
  function automatic logic is_capture(input logic [2:0] m);
    is_capture = (m == mm_timer_pkg::MODE_CAPT_RISE) || (m == mm_timer_pkg::MODE_CAPT_FALL);
  endfunction : is_capture

  function automatic logic is_event(input logic [2:0] m);
    is_event = (m == mm_timer_pkg::MODE_EVENT_RISE) || (m == mm_timer_pkg::MODE_EVENT_FALL);
  endfunction : is_event

  logic capture_mode;
  logic event_mode;
  logic pwm_mode;
  logic falling_sel;
  assign capture_mode = is_capture(mode_r);
  assign event_mode   = is_event(mode_r);
  assign pwm_mode     = (mode_r == mm_timer_pkg::MODE_PWM_PLAIN) || (mode_r == mm_timer_pkg::MODE_PWM_TOGGLE);
  // odd codes pick the falling edge in event and capture modes
  assign falling_sel  = mode_r[0];

  // ****************************************
  // pin synchroniser and edge detect
  // ****************************************
  // three-stage sync
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_sync_r <= 3'h0;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], timer_pin_in};
    end
  end

  // level changes only when stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_level_r <= 1'b0;
    end else if (pin_sync_r[1] == pin_sync_r[2]) begin
      pin_level_r <= pin_sync_r[2];
    end
  end

  logic pin_rise;
  logic pin_fall;
  logic pin_edge;
  assign pin_rise = (pin_sync_r[1] == pin_sync_r[2]) && pin_sync_r[2] && !pin_level_r;
  assign pin_fall = (pin_sync_r[1] == pin_sync_r[2]) && !pin_sync_r[2] && pin_level_r;
  assign pin_edge = falling_sel ? pin_fall : pin_rise;

  // ****************************************
  // count and underflow
  // ****************************************
  logic running;
  logic tick;
  logic underflow;
  logic capture_evt;
  logic wr_cnt_lo;
  logic wr_cnt_hi;
  logic wr_rl_lo;
  logic wr_rl_hi;
  logic wr_ctrl;

  assign wr_cnt_lo = wr_en && (addr == mm_timer_pkg::ADDR_COUNT_LOW);
  assign wr_cnt_hi = wr_en && (addr == mm_timer_pkg::ADDR_COUNT_HIGH);
  assign wr_rl_lo  = wr_en && (addr == mm_timer_pkg::ADDR_RELOAD_LOW);
  assign wr_rl_hi  = wr_en && (addr == mm_timer_pkg::ADDR_RELOAD_HIGH);
  assign wr_ctrl   = wr_en && (addr == mm_timer_pkg::ADDR_CONTROL);

  // capture mode always runs, else run bit
  assign running     = capture_mode || run_or_underflow_r;
  assign tick        = running && (event_mode ? pin_edge : 1'b1);
  assign underflow   = tick && (down_counter_r == 16'h0000);
  assign capture_evt = capture_mode && pin_edge;

  always_ff @(posedge clk) begin
    if (rst) begin
      down_counter_r <= mm_timer_pkg::COUNT_RESET;
    end else if (wr_cnt_lo) begin
      down_counter_r[7:0] <= wr_data;
    end else if (wr_cnt_hi) begin
      down_counter_r[15:8] <= wr_data;
    end else if (underflow && !capture_mode) begin
      down_counter_r <= reload_capture_r;
    end else if (tick) begin
      down_counter_r <= down_counter_r - 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reload_capture_r <= mm_timer_pkg::RELOAD_RESET;
    end else if (capture_evt) begin
      reload_capture_r <= down_counter_r;
    end else if (wr_rl_lo) begin
      reload_capture_r[7:0] <= wr_data;
    end else if (wr_rl_hi) begin
      reload_capture_r[15:8] <= wr_data;
    end
  end

  // ****************************************
  // control register
  // ****************************************
  // mode field and interrupt enable
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_r             <= mm_timer_pkg::CTRL_RESET[mm_timer_pkg::MODE_MSB:mm_timer_pkg::MODE_LSB];
      timer_irq_enable_r <= mm_timer_pkg::CTRL_RESET[mm_timer_pkg::IRQ_EN_BIT];
    end else if (wr_ctrl) begin
      mode_r             <= wr_data[mm_timer_pkg::MODE_MSB:mm_timer_pkg::MODE_LSB];
      timer_irq_enable_r <= wr_data[mm_timer_pkg::IRQ_EN_BIT];
    end
  end

  // run bit; underflow flag in capture, set wins
  always_ff @(posedge clk) begin
    if (rst) begin
      run_or_underflow_r <= mm_timer_pkg::CTRL_RESET[mm_timer_pkg::RUN_BIT];
    end else if (capture_mode && underflow) begin
      run_or_underflow_r <= 1'b1;
    end else if (wr_ctrl) begin
      run_or_underflow_r <= wr_data[mm_timer_pkg::RUN_BIT];
    end
  end

  // pending flag; source by mode; set wins over clear
  always_ff @(posedge clk) begin
    if (rst) begin
      timer_pending_r <= mm_timer_pkg::CTRL_RESET[mm_timer_pkg::PENDING_BIT];
    end else if (capture_mode ? capture_evt : underflow) begin
      timer_pending_r <= 1'b1;
    end else if (wr_ctrl) begin
      timer_pending_r <= wr_data[mm_timer_pkg::PENDING_BIT];
    end
  end

  // ****************************************
  // pin toggle and interrupt
  // ****************************************
  // toggle on underflow in toggle pwm
  always_ff @(posedge clk) begin
    if (rst) begin
      toggle_r <= 1'b0;
    end else if (underflow && (mode_r == mm_timer_pkg::MODE_PWM_TOGGLE)) begin
      toggle_r <= ~toggle_r;
    end
  end

  // pin follows port bit two xor toggle when pwm toggle mode
  assign timer_pin_is_timer = (mode_r == mm_timer_pkg::MODE_PWM_TOGGLE);
  assign timer_pin_toggle   = toggle_r;
  assign timer_pin_out      = port_bit_two_out[2] ^ toggle_r;

  assign timer_irq = global_irq_enable && timer_irq_enable_r &&
                     (timer_pending_r || (capture_mode && run_or_underflow_r));

  // ****************************************
  // read mux
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= 8'h00;
      rd_hit  <= 1'b0;
    end else begin
      rd_hit <= rd_en && (addr inside {mm_timer_pkg::ADDR_RELOAD_LOW, mm_timer_pkg::ADDR_RELOAD_HIGH,
                 mm_timer_pkg::ADDR_COUNT_LOW, mm_timer_pkg::ADDR_COUNT_HIGH, mm_timer_pkg::ADDR_CONTROL});
      if (!rd_en) begin
        rd_data <= 8'h00;
      end else begin
        unique case (addr)
          mm_timer_pkg::ADDR_RELOAD_LOW:  rd_data <= reload_capture_r[7:0];
          mm_timer_pkg::ADDR_RELOAD_HIGH: rd_data <= reload_capture_r[15:8];
          mm_timer_pkg::ADDR_COUNT_LOW:   rd_data <= down_counter_r[7:0];
          mm_timer_pkg::ADDR_COUNT_HIGH:  rd_data <= down_counter_r[15:8];
          mm_timer_pkg::ADDR_CONTROL:     rd_data <= {mode_r, run_or_underflow_r, timer_pending_r,
                                                      timer_irq_enable_r, 2'b00};
          default:                        rd_data <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_reset_values;
    @(posedge clk) rst |=> (down_counter_r == 16'hffff) && (reload_capture_r == 16'h0000);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

  property p_reload;
    @(posedge clk) disable iff (rst)
      (underflow && !capture_mode && !wr_cnt_lo && !wr_cnt_hi) |=> down_counter_r == $past(reload_capture_r);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload on underflow");

  property p_decrement;
    @(posedge clk) disable iff (rst)
      (tick && !underflow && !wr_cnt_lo && !wr_cnt_hi) |=> down_counter_r == $past(down_counter_r) - 16'h0001;
  endproperty
  a_decrement: assert property (p_decrement) else $error("counter did not decrement");

  property p_stopped;
    @(posedge clk) disable iff (rst)
      (!running && !wr_cnt_lo && !wr_cnt_hi) |=> $stable(down_counter_r);
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped counter moved");

  property p_capture;
    @(posedge clk) disable iff (rst)
      capture_evt |=> (reload_capture_r == $past(down_counter_r)) && timer_pending_r;
  endproperty
  a_capture: assert property (p_capture) else $error("capture failed");

  // capture mode wraps instead of reloading, flag in bit 4
  property p_capture_wrap;
    @(posedge clk) disable iff (rst)
      (capture_mode && underflow && !wr_cnt_lo && !wr_cnt_hi) |=>
        run_or_underflow_r && (down_counter_r == 16'hffff);
  endproperty
  a_capture_wrap: assert property (p_capture_wrap) else $error("capture underflow not flagged");

  property p_pending_set;
    @(posedge clk) disable iff (rst) (underflow && !capture_mode) |=> timer_pending_r;
  endproperty
  a_pending_set: assert property (p_pending_set) else $error("pending not set");

  property p_irq_gate;
    @(posedge clk) disable iff (rst) timer_irq |-> global_irq_enable && timer_irq_enable_r;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enables");

  property p_toggle;
    @(posedge clk) disable iff (rst)
      (underflow && mode_r == mm_timer_pkg::MODE_PWM_TOGGLE) |=> toggle_r != $past(toggle_r);
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin did not toggle");

  property p_edge_once;
    @(posedge clk) disable iff (rst) pin_rise |=> !pin_rise;
  endproperty
  a_edge_once: assert property (p_edge_once) else $error("edge seen twice");

  c_underflow_pwm: cover property (@(posedge clk) disable iff (rst) underflow && pwm_mode);
  c_event_count:   cover property (@(posedge clk) disable iff (rst) tick && event_mode);
  c_capture:       cover property (@(posedge clk) disable iff (rst) capture_evt);
  c_capture_wrap:  cover property (@(posedge clk) disable iff (rst) capture_mode && underflow);
  c_irq:           cover property (@(posedge clk) disable iff (rst) timer_irq);

endmodule : mm_timer

// [dv/pin_source.sv]
// Purpose: external pulse source driving the timer pin
// Assumes: paced by the bench clock, changes at the falling edge
// Notes:   keeps the cycle number of its latest rise and fall
`timescale 1ns/10ps

module pin_source (
  // clock
  input  wire logic clk,
  // timer pin
  output logic      pin
);
  int cyc    = 0;
  int t_rise = 0;
  int t_fall = 0;

  always @(posedge clk) begin
    cyc <= cyc + 1;
  end

  initial begin
    pin = 1'b0;
  end

  // levels held 3 clocks at least, shorter ones may be dropped as glitches
  task automatic pulse(input int hi, input int lo);
    @(negedge clk);
    pin = 1'b1;
    t_rise = cyc;
    repeat ((hi < 3) ? 3 : hi) @(negedge clk);
    pin = 1'b0;
    t_fall = cyc;
    repeat ((lo < 3) ? 3 : lo) @(negedge clk);
  endtask : pulse
endmodule : pin_source

// [dv/tb.sv]
// Purpose: self-checking bench for the multimode timer
// Assumes: byte access through the timer's own register strobes
// Notes:   expectations come from an integer model of counter and flags
`timescale 1ns/10ps

module tb;
  logic        clk      = 1'b0;
  logic        rst      = 1'b1;
  logic [7:0]  addr     = 8'h00;
  logic        wr_en    = 1'b0;
  logic [7:0]  wr_data  = 8'h00;
  logic        rd_en    = 1'b0;
  logic [7:0]  rd_data;
  logic        rd_hit;
  logic        gie      = 1'b0;
  logic        timer_irq;
  logic        pin;
  logic [7:0]  port_out = 8'h00;
  logic        tgl;
  logic        pin_out;
  logic        is_timer;
  logic [15:0] v;
  int          err_total    = 0;
  int          total_checks = 0;
  int          cnt, rel, pend, k, n, c1;
  int          tog = 0;
  int          stamps[$];

  always #5 clk = ~clk;

  mm_timer mm_timer_i (.clk(clk), .rst(rst), .addr(addr), .wr_en(wr_en), .wr_data(wr_data), .rd_en(rd_en),
    .rd_data(rd_data), .rd_hit(rd_hit), .global_irq_enable(gie), .timer_irq(timer_irq), .timer_pin_in(pin),
    .port_bit_two_out(port_out), .timer_pin_toggle(tgl), .timer_pin_out(pin_out), .timer_pin_is_timer(is_timer));
  pin_source pin_source_i (.clk(clk), .pin(pin));

  // ****************************************
  // bus access and comparison
  // ****************************************
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d, input logic hit);
    @(negedge clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge clk);
    rd_en = 1'b0;
    d = rd_data;
    chk("rd_hit", 16'(rd_hit), 16'(hit));
  endtask : rd

  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(a + 8'h01, d[15:8]);
  endtask : wr16

  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    rd(a, d[7:0], 1'b1);
    rd(a + 8'h01, d[15:8], 1'b1);
  endtask : rd16

  task automatic conclude;
    if (err_total == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    conclude();
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    void'($urandom(32'h70eb583c));
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rd16(mm_timer_pkg::ADDR_COUNT_LOW, v);
    chk("count reset", v, 16'hffff);
    rd16(mm_timer_pkg::ADDR_RELOAD_LOW, v);
    chk("reload reset", v, 16'h0000);
    rd(8'haf, v[7:0], 1'b0);
    chk("unmapped", {8'h00, v[7:0]}, 16'h0000);
    port_out = 8'($urandom);
    c1 = $urandom_range(255);
    wr(mm_timer_pkg::ADDR_CONTROL, 8'(c1));
    rd(mm_timer_pkg::ADDR_CONTROL, v[7:0], 1'b1);
    chk("ctrl readback", {8'h00, v[7:0]}, 16'(c1 & 8'hfc));
    chk("pin owner", 16'(is_timer), 16'(c1[7:5] == 3'h5));
    chk("pin level", 16'(pin_out), 16'(port_out[2]));
    for (int m = 0; m < 2; m++) begin
      cnt = 2;
      rel = 1;
      pend = 0;
      gie = 1'($urandom);
      wr(mm_timer_pkg::ADDR_CONTROL, 8'h00);
      wr16(mm_timer_pkg::ADDR_RELOAD_LOW, 16'(rel));
      wr16(mm_timer_pkg::ADDR_COUNT_LOW, 16'(cnt));
      wr(mm_timer_pkg::ADDR_CONTROL, {3'(m), 5'h14});
      n = 1 + $urandom_range(5);
      for (k = 0; k < n; k++) begin
        pin_source_i.pulse(3 + $urandom_range(2), 4);
        if (cnt == 0) begin
          cnt = rel;
          pend = 1;
        end else begin
          cnt--;
        end
      end
      repeat (4) @(negedge clk);
      rd16(mm_timer_pkg::ADDR_COUNT_LOW, v);
      chk("event count", v, 16'(cnt));
      rd(mm_timer_pkg::ADDR_CONTROL, v[7:0], 1'b1);
      chk("event pending", 16'(v[3]), 16'(pend));
      chk("event irq", 16'(timer_irq), 16'(pend & gie));
    end
    for (int m = 4; m < 6; m++) begin
      rel = 3 + $urandom_range(4);
      gie = 1'($urandom);
      wr(mm_timer_pkg::ADDR_CONTROL, 8'h00);
      wr16(mm_timer_pkg::ADDR_RELOAD_LOW, 16'(rel));
      wr(mm_timer_pkg::ADDR_CONTROL, {3'(m), 5'h14});
      chk("pwm owner", 16'(is_timer), 16'(m == 5));
      for (k = 0; k < 2; k++) begin
        c1 = tgl;
        n = 0;
        while (tgl === 1'(c1) && n < 300) begin
          @(negedge clk);
          n++;
        end
        // each underflow flips the pin in toggle mode
        if (m == 5) tog ^= 1;
      end
      chk("pwm period", 16'(n), 16'((m == 5) ? rel + 1 : 300));
      chk("pwm toggle", 16'(tgl), 16'(tog));
      chk("pwm pin", 16'(pin_out), 16'(port_out[2] ^ 1'(tog)));
      rd(mm_timer_pkg::ADDR_CONTROL, v[7:0], 1'b1);
      chk("pwm ctrl", {8'h00, v[7:0]}, 16'({3'(m), 5'h1c}));
      chk("pwm irq", 16'(timer_irq), 16'(gie));
    end
    for (int m = 2; m < 4; m++) begin
      wr(mm_timer_pkg::ADDR_CONTROL, {3'(m), 5'h04});
      pin_source_i.pulse(3 + $urandom_range(5), 6);
      rd16(mm_timer_pkg::ADDR_RELOAD_LOW, v);
      c1 = v;
      stamps.push_back((m == 2) ? pin_source_i.t_rise : pin_source_i.t_fall);
      pin_source_i.pulse(3 + $urandom_range(5), 6);
      rd16(mm_timer_pkg::ADDR_RELOAD_LOW, v);
      stamps.push_back((m == 2) ? pin_source_i.t_rise : pin_source_i.t_fall);
      chk("capture gap", v, 16'(c1 - (stamps[1] - stamps[0])));
      stamps.delete();
      rd(mm_timer_pkg::ADDR_CONTROL, v[7:0], 1'b1);
      chk("capture pending", 16'(v[3]), 16'h0001);
      // pwm left the count small, so only the first capture pass wraps
      chk("capture underflow", 16'(v[4]), 16'(m == 2));
      chk("capture irq", 16'(timer_irq), 16'(gie));
    end
    conclude();
  end
endmodule : tb
